// *** bre_core.sv ***
// Byte-rotate execution unit with its data register file and an APB register port.
// Assumes APB from the same clock domain; every transfer completes one cycle into the access phase.
// Assumes the data memory is loaded over the bus before a rotate names it.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
module bre_core #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);
  import bre_pkg::*;

  localparam int unsigned DEPTH = 1 << ADDR_W;

  logic [7:0]        dataMem [DEPTH];
  logic              pready_ff;
  logic [31:0]       prdata_ff;
  logic              pslverr_ff;
  logic [7:0]        workReg_ff;
  logic [3:0]        bankSel_ff;
  bre_flags_t        flags_ff;
  logic              extSet_ff;
  logic [ADDR_W-1:0] idxBase_ff;
  logic [ADDR_W-1:0] memAddr_ff;
  logic [15:0]       lastInstr_ff;
  logic [ADDR_W-1:0] lastAddr_ff;
  logic              lastIllegal_ff;

  logic              xferDone;
  logic              wrDone;
  logic              mapped;
  logic              exec;
  bre_instr_t        instr;
  logic              isLeft;
  logic              isRight;
  logic [ADDR_W-1:0] effAddr;
  logic [7:0]        operandVal;
  logic [7:0]        result;
  logic              nxt_carry;
  logic [31:0]       nxt_prdata;
  logic              accessFirst;
  logic              rotExec;

  // Resolves the data address an instruction names from its access bit and operand byte.
  function automatic logic [ADDR_W-1:0] resolve_addr(
    input logic              acc,
    input logic [7:0]        opnd,
    input logic              extOn,
    input logic [3:0]        bank,
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W-1:0] addr;
    addr = '0;
    if (acc) begin
      addr = ADDR_W'({bank, opnd});
    end else if (extOn && (opnd <= ACCESS_LOW_LAST)) begin
      addr = base + ADDR_W'(opnd);
    end else begin
      addr = ADDR_W'({(opnd <= ACCESS_LOW_LAST) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, opnd});
    end
    return addr;
  endfunction : resolve_addr

  assign pready   = pready_ff;
  assign prdata   = prdata_ff;
  assign pslverr  = pslverr_ff;

  assign xferDone = psel && penable && pready_ff;
  assign wrDone   = xferDone && pwrite;
  // Only an access cycle with ready low launches an answer, so a request that is held is answered again every second cycle.
  assign accessFirst = psel && penable && !pready_ff;

  always_comb begin
    unique case (paddr)
      REG_INSTR, REG_WORK, REG_BANK, REG_STATUS, REG_CTRL,
      REG_IDXBASE, REG_MEMADDR, REG_MEMDATA, REG_EXECINFO: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign instr   = bre_instr_t'(pwdata[INSTR_W-1:0]);
  assign exec    = wrDone && (paddr == REG_INSTR);
  assign isLeft  = instr.opcode == OP_ROTATE_LEFT_NO_CARRY;
  assign isRight = instr.opcode == OP_ROTATE_RIGHT_VIA_CARRY;
  assign rotExec = exec && (isLeft || isRight);
  assign effAddr = resolve_addr(instr.acc, instr.operand, extSet_ff, bankSel_ff, idxBase_ff);
  assign operandVal = dataMem[effAddr];

  always_comb begin
    result    = operandVal;
    nxt_carry = flags_ff.c;
    if (isLeft) begin
      // bit 7 wraps to bit 0
      result = {operandVal[6:0], operandVal[7]};
    end else if (isRight) begin
      result    = {flags_ff.c, operandVal[7:1]};
      nxt_carry = operandVal[0];
    end
  end

  // The answer is registered so every bus output leaves a flip-flop; each transfer costs one wait state.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= accessFirst;
      // An unmapped write is answered with an error and changes nothing.
      pslverr_ff <= accessFirst && !mapped;
      prdata_ff  <= (accessFirst && !pwrite) ? nxt_prdata : 32'h0000_0000;
    end
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      REG_INSTR:    nxt_prdata = 32'(lastInstr_ff);
      REG_WORK:     nxt_prdata = 32'(workReg_ff);
      REG_BANK:     nxt_prdata = 32'(bankSel_ff);
      REG_STATUS: begin
        nxt_prdata[STAT_C_BIT] = flags_ff.c;
        nxt_prdata[STAT_Z_BIT] = flags_ff.z;
        nxt_prdata[STAT_N_BIT] = flags_ff.n;
      end
      REG_CTRL:     nxt_prdata = 32'(extSet_ff);
      REG_IDXBASE:  nxt_prdata = 32'(idxBase_ff);
      REG_MEMADDR:  nxt_prdata = 32'(memAddr_ff);
      REG_MEMDATA:  nxt_prdata = 32'(dataMem[memAddr_ff]);
      REG_EXECINFO: nxt_prdata = {15'h0000, lastIllegal_ff, 16'(lastAddr_ff)};
      default:      nxt_prdata = 32'h0000_0000;
    endcase
  end

  // Configuration written by software: bank select, extended set enable, index base, memory pointer.
  // The execution record is read-only; a write there is answered and dropped.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bankSel_ff <= RST_BANK;
      extSet_ff  <= RST_EXTSET;
      idxBase_ff <= RST_IDXBASE[ADDR_W-1:0];
      memAddr_ff <= RST_MEMADDR[ADDR_W-1:0];
    end else if (wrDone) begin
      if (paddr == REG_BANK) begin
        bankSel_ff <= pwdata[3:0];
      end
      if (paddr == REG_CTRL) begin
        extSet_ff <= pwdata[0];
      end
      if (paddr == REG_IDXBASE) begin
        idxBase_ff <= pwdata[ADDR_W-1:0];
      end
      if (paddr == REG_MEMADDR) begin
        memAddr_ff <= pwdata[ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      workReg_ff <= RST_WORK;
    end else if (rotExec && !instr.dest) begin
      workReg_ff <= result;
    end else if (wrDone && (paddr == REG_WORK)) begin
      workReg_ff <= pwdata[7:0];
    end
  end

  // The register file has no reset, as a real data memory would not; software loads it first.
  always_ff @(posedge clk) begin
    if (rotExec && instr.dest) begin
      dataMem[effAddr] <= result;
    end else if (wrDone && (paddr == REG_MEMDATA)) begin
      dataMem[memAddr_ff] <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_ff <= RST_FLAGS;
    end else if (rotExec) begin
      // both rotates set N and Z; only right rotate changes C
      flags_ff.c <= nxt_carry;
      flags_ff.n <= result[7];
      flags_ff.z <= result == 8'h00;
    end else if (wrDone && (paddr == REG_STATUS)) begin
      // A rotate and a status write use different addresses, so they never meet.
      flags_ff.c <= pwdata[STAT_C_BIT];
      flags_ff.z <= pwdata[STAT_Z_BIT];
      flags_ff.n <= pwdata[STAT_N_BIT];
    end
  end

  // Any other opcode is not executed here; it is only recorded so software can see it was dropped.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lastInstr_ff   <= RST_INSTR;
      lastAddr_ff    <= '0;
      lastIllegal_ff <= 1'b0;
    end else if (exec) begin
      // Software reads the dropped-opcode flag and the resolved address back later.
      lastInstr_ff   <= pwdata[INSTR_W-1:0];
      lastAddr_ff    <= effAddr;
      lastIllegal_ff <= !(isLeft || isRight);
    end
  end

endmodule : bre_core

// *** bre_pkg.sv ***
// Constants, field layouts and carrier types for the byte-rotate execution block.
// Assumes a single 10 MHz core clock and an APB master with 32-bit data.
// What this block does
// - rotate left, bit 7 wraps, carry kept
// - d=0 writes working register, d=1 writes source
// - a=0 uses access bank, ignores bank select
// - a=1 joins bank select with operand byte
// - extended set, a=0, f<=95 uses indexed offset
package bre_pkg;

  // APB byte offsets.
  localparam logic [7:0] REG_INSTR    = 8'h00;
  localparam logic [7:0] REG_WORK     = 8'h04;
  localparam logic [7:0] REG_BANK     = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0c;
  localparam logic [7:0] REG_CTRL     = 8'h10;
  localparam logic [7:0] REG_IDXBASE  = 8'h14;
  localparam logic [7:0] REG_MEMADDR  = 8'h18;
  localparam logic [7:0] REG_MEMDATA  = 8'h1c;
  localparam logic [7:0] REG_EXECINFO = 8'h20;

  // Instruction word layout and opcodes.
  localparam int unsigned INSTR_W  = 16;
  localparam logic [5:0]  OP_ROTATE_LEFT_NO_CARRY  = 6'h11;
  localparam logic [5:0]  OP_ROTATE_RIGHT_VIA_CARRY = 6'h0c;

  // Operand byte at or below this value is in the low access window.
  localparam logic [7:0] ACCESS_LOW_LAST = 8'h5f;
  // Upper access window sits in the top bank.
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;

  // Status bit positions in the STATUS register.
  localparam int unsigned STAT_C_BIT = 0;
  localparam int unsigned STAT_Z_BIT = 2;
  localparam int unsigned STAT_N_BIT = 4;

  // Reset values.
  localparam logic [7:0]  RST_WORK    = 8'h00;
  localparam logic [3:0]  RST_BANK    = 4'h0;
  localparam logic [11:0] RST_IDXBASE = 12'h000;
  localparam logic [15:0] RST_INSTR   = 16'h0000;
  localparam logic        RST_EXTSET  = 1'b0;
  localparam logic [11:0] RST_MEMADDR = 12'h000;

  typedef struct packed {
    logic [5:0] opcode;
    logic       dest;
    logic       acc;
    logic [7:0] operand;
  } bre_instr_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
  } bre_flags_t;

  localparam bre_flags_t RST_FLAGS = '{n: 1'b0, z: 1'b0, c: 1'b0};

endpackage : bre_pkg

// *** bre_core_monitor.sv ***
// Concurrent checks on the APB port of the byte-rotate execution block.
// Assumes it is bound to bre_core and sees only that module's ports.
`timescale 1ns/1ps
module bre_core_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence accessStart;
    psel && $rose(penable);
  endsequence
  sequence mappedAnswer;
    pready && paddr <= 8'h20 && paddr[1:0] == 2'h0;
  endsequence
  AST_READY_SECOND:
    assert property (accessStart |=> pready) else $error("Access phase not answered in its second cycle.");
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("Ready stood longer than one cycle.");
  AST_READY_CAUSE:
    assert property (pready |-> psel && penable && $past(penable)) else $error("Ready without a held access.");
  AST_ERR_WITH_READY:
    assert property (pslverr |-> pready) else $error("Error flag outside an answer.");
  AST_RDATA_IDLE:
    assert property (!pready |-> prdata == 32'h0) else $error("Read data not zero outside an answer.");
  AST_ERR_UNMAPPED:
    assert property (pready && paddr > 8'h20 |-> pslverr) else $error("Unmapped access not flagged.");
  AST_ERR_MAPPED:
    assert property (mappedAnswer |-> !pslverr) else $error("Mapped access flagged as error.");
endmodule : bre_core_monitor

// *** bre_core_bench.sv ***
// Self-checking bench for the byte-rotate execution block, driven over APB.
// Assumes bre_core answers every access; the checker is bound at the foot.
`timescale 1ns/1ps
module bre_core_bench;
  import bre_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  logic [32:0] expQ[$];
  int          fails = 0, num_checks = 0;
  always #50 clk = ~clk;
  bre_core u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // Psel stays up between transfers so that back-to-back setups need no extra edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    if (!w) expQ.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    // The answer is awaited without a limit of its own; the watchdog ends a hang.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    penable <= 1'b0;
  endtask : xfer
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      // A read answer with nothing expected is itself a mismatch.
      if (expQ.size() == 0) fails++;
      else check({pslverr, prdata}, expQ.pop_front());
    end
  end
  initial begin
    logic [31:0] r;
    logic [7:0]  v, f, res;
    logic [3:0]  bnk;
    logic [11:0] base, ea;
    logic        d, a, c;
    void'($urandom(88));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, REG_WORK, 32'h0, {25'h0, RST_WORK});
    xfer(1'b0, REG_STATUS, 32'h0, 33'h0);
    xfer(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    c = 1'b0;
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      {v, f, bnk, base} = r;
      r = $urandom;
      d = r[1];
      a = r[2];
      if (a) ea = {bnk, f};
      else if (r[3] && f <= ACCESS_LOW_LAST) ea = base + {4'h0, f};
      else ea = {(f <= ACCESS_LOW_LAST) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
      if (r[0]) res = {v[6:0], v[7]};
      else begin
        res = {c, v[7:1]};
        c   = v[0];
      end
      xfer(1'b1, REG_BANK, {28'h0, bnk}, 33'h0);
      xfer(1'b1, REG_CTRL, {31'h0, r[3]}, 33'h0);
      xfer(1'b1, REG_IDXBASE, {20'h0, base}, 33'h0);
      xfer(1'b1, REG_MEMADDR, {20'h0, ea}, 33'h0);
      xfer(1'b1, REG_MEMDATA, {24'h0, v}, 33'h0);
      xfer(1'b1, REG_INSTR, {16'h0, r[0] ? OP_ROTATE_LEFT_NO_CARRY : OP_ROTATE_RIGHT_VIA_CARRY, d, a, f}, 33'h0);
      xfer(1'b0, d ? REG_MEMDATA : REG_WORK, 32'h0, {25'h0, res});
      if (!d) xfer(1'b0, REG_MEMDATA, 32'h0, {25'h0, v});
      xfer(1'b0, REG_STATUS, 32'h0, {28'h0, res[7], 1'b0, res == 8'h0, 1'b0, c});
      xfer(1'b0, REG_EXECINFO, 32'h0, {21'h0, ea});
    end
    // An unsupported opcode changes nothing but the execution record.
    xfer(1'b1, REG_INSTR, {16'h0, 6'h3f, 1'b1, 1'b1, 8'h00}, 33'h0);
    xfer(1'b0, REG_INSTR, 32'h0, {17'h0, 6'h3f, 1'b1, 1'b1, 8'h00});
    xfer(1'b0, REG_EXECINFO, 32'h0, {16'h0001, 4'h0, bnk, 8'h00});
    xfer(1'b0, REG_STATUS, 32'h0, {28'h0, res[7], 1'b0, res == 8'h0, 1'b0, c});
    psel <= 1'b0;
    repeat (2) @(posedge clk);
    if (expQ.size() != 0) fails++;
    stop_test();
  end
  initial begin
    #1000000;
    fails++;
    stop_test();
  end
endmodule : bre_core_bench
bind bre_core bre_core_monitor u_mon (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
  .pslverr);
